/* File: core/alpm_defs.vh */
// register offsets, field positions, reset values and encodings of the low-power converter control
// assumes a 32-bit avalon-mm slave with word-aligned registers
`ifndef ALPM_DEFS_VH
`define ALPM_DEFS_VH
// ************************************************
// register word addresses
// ************************************************
`define ALPM_OFS_CFG 4'h0
`define ALPM_OFS_SC2 4'h1
`define ALPM_OFS_SC1 4'h2
`define ALPM_OFS_RESH 4'h3
`define ALPM_OFS_RESL 4'h4
`define ALPM_OFS_CMPH 4'h5
`define ALPM_OFS_CMPL 4'h6
`define ALPM_OFS_PIN1 4'h7
`define ALPM_OFS_PIN2 4'h8
`define ALPM_OFS_PWR 4'h9
// ************************************************
// field positions
// ************************************************
`define ALPM_CFG_LPC 7
`define ALPM_CFG_DIV_HI 6
`define ALPM_CFG_DIV_LO 5
`define ALPM_CFG_LSMP 4
`define ALPM_CFG_MODE_HI 3
`define ALPM_CFG_MODE_LO 2
`define ALPM_CFG_ICLK_HI 1
`define ALPM_CFG_ICLK_LO 0
`define ALPM_SC2_ACT 7
`define ALPM_SC2_TRG 6
`define ALPM_SC2_CFE 5
`define ALPM_SC2_CGT 4
`define ALPM_SC1_CONVERSION_COMPLETE_FLAG 7
`define ALPM_SC1_IEN 6
`define ALPM_SC1_CONT 5
// ************************************************
// encodings and reset values
// ************************************************
`define ALPM_ICLK_BUS 2'h0
`define ALPM_ICLK_BUS2 2'h1
`define ALPM_ICLK_ALT 2'h2
`define ALPM_ICLK_ASYNC 2'h3
`define ALPM_MODE_8 2'h0
`define ALPM_MODE_10 2'h2
`define ALPM_RST_CFG 8'h00
`define ALPM_RST_SC2 8'h00
`define ALPM_RST_SC1 8'h1F
`define ALPM_RST_BYTE 8'h00
`define ALPM_PWR_RUN 2'h0
`define ALPM_PWR_WAIT 2'h1
`define ALPM_PWR_STOP3 2'h2
`define ALPM_PWR_STOP2 2'h3
`define ALPM_CONV_CYC 8'h17
`endif

/* File: core/alpm_conv_seq.v */
// conversion sequencer: counts out one conversion in conversion clock ticks
// assumes a one-cycle tick enable from the parent and an external sar result
`default_nettype none
module alpm_conv_seq #(
    parameter CYC_W = 8
) (
    input wire core_clk,
    input wire srst,
    input wire tick,
    input wire start,
    input wire abort,
    input wire [CYC_W-1:0] cycles,
    output wire busy,
    output reg done_ff
);
    // ************************************************
    // states
    // ************************************************
    localparam ST_IDLE = 2'b01;
    localparam ST_RUN = 2'b10;
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [CYC_W-1:0] cnt_ff;
    reg [CYC_W-1:0] nxt_cnt;
    reg nxt_done;
    assign busy = state_ff[1];
    // next state; abort beats start and completion
    always @* begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_done = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (start && !abort) begin
                    nxt_state = ST_RUN;
                    nxt_cnt = cycles;
                end
            end
            ST_RUN: begin
                if (abort) begin
                    nxt_state = ST_IDLE;
                end else if (tick) begin
                    if (cnt_ff <= {{(CYC_W-1){1'b0}}, 1'b1}) begin
                        nxt_state = ST_IDLE;
                        nxt_done = 1'b1;
                    end else begin
                        nxt_cnt = cnt_ff - {{(CYC_W-1){1'b0}}, 1'b1};
                    end
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end
    // state registers
    always @(posedge core_clk) begin
        if (srst) begin
            state_ff <= ST_IDLE;
            cnt_ff <= {CYC_W{1'b0}};
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            done_ff <= nxt_done;
        end
    end
endmodule // alpm_conv_seq
`default_nettype wire

/* File: core/alpm_ctrl.v */
// low-power mode control of a successive-approximation converter, with its register file
// assumes an avalon-mm master on core_clk and power-mode/trigger inputs synchronous to it
//
// Summary of operation
// - a running conversion completes when the host enters wait
// - in wait, new starts only from hardware trigger or continuous mode
// - bus, bus/2 and async clocks all remain usable in wait
// - completion in wait sets flag and raises wake interrupt when enabled
// - stop3 without async clock aborts the conversion and idles the controller
// - result bytes keep their contents through stop3
// - after aborted stop3, a new write or trigger is needed to convert
// - with async clock selected, the converter keeps operating in stop3
// - async stop3: running conversion completes; starts only by trigger or continuous
// - completion in stop3 sets flag and wakes host when enabled
// - stop2 disables the converter; all registers return to reset values
// - config: low power 7, divider 6:5, long sample 4, mode 3:2, clock 1:0
// - divider 00 is divide by one, mode 10 is ten bits, clock 00 bus
// - second control: active 7, trigger 6, compare enable 5, greater 4
// - second control bits 3:2 read zero; bits 1:0 written zero
// - first control: complete 7, irq enable 6, continuous 5, channel 4:0
// - high byte read locks the result until the low byte is read
// - a set pin control bit disables digital control of that analog input
`include "alpm_defs.vh"
`default_nettype none
module alpm_ctrl #(
    parameter N_PINS = 16
) (
    input wire core_clk,
    input wire srst,
    // avalon-mm slave
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    output reg [1:0] avs_response,
    // host power state and converter side
    input wire [1:0] power_mode,
    input wire hw_trigger,
    input wire async_clk_tick,
    input wire alt_clk_tick,
    input wire [9:0] sar_result,
    input wire compare_hit_unused,
    output reg complete_irq_ff,
    output reg converter_enable_ff,
    output reg [N_PINS-1:0] pin_digital_disable_ff,
    output reg [4:0] channel_out_ff
);
    // ************************************************
    // registers
    // ************************************************
    reg [7:0] cfg_ff;
    reg [7:0] sc2_ff;
    reg [7:0] sc1_ff;
    reg conversion_complete_flag_ff;
    reg [9:0] result_ff;
    reg [9:0] cmp_ff;
    reg lock_ff;
    reg [7:0] pin1_ff;
    reg [7:0] pin2_ff;
    reg bus_div_ff;
    reg ack_ff;
    reg [1:0] mode_q_ff;
    reg sw_start_ff;
    reg parked_ff;
    wire busy;
    wire conv_done;
    wire [1:0] iclk;
    wire in_low_power;
    wire async_sel;
    wire abort_stop3;
    wire stop2;
    wire tick;
    wire start;
    wire wr_hit;
    wire rd_hit;
    wire cmp_ok;
    wire [10:0] diff;
    wire [9:0] eff_result;
    // byte lane 0 enabled in the byte enables
    function be_ok;
        input [3:0] be;
        begin
            be_ok = be[0];
        end
    endfunction
    // result width by mode: 8-bit mode masks the top two bits
    function [9:0] mode_mask;
        input [1:0] m;
        input [9:0] v;
        begin
            mode_mask = (m == `ALPM_MODE_10) ? v : {2'b00, v[7:0]};
        end
    endfunction
    assign iclk = cfg_ff[`ALPM_CFG_ICLK_HI:`ALPM_CFG_ICLK_LO];
    assign async_sel = (iclk == `ALPM_ICLK_ASYNC);
    assign stop2 = (power_mode == `ALPM_PWR_STOP2);
    assign in_low_power = (power_mode == `ALPM_PWR_WAIT) || (power_mode == `ALPM_PWR_STOP3);
    // stop3 halts every clock but the async one
    assign abort_stop3 = (power_mode == `ALPM_PWR_STOP3) && !async_sel;
    // ************************************************
    // conversion clock selection
    // ************************************************
    // all sources stay live in wait; only async survives stop3
    assign tick = (iclk == `ALPM_ICLK_BUS) ? 1'b1 :
                  (iclk == `ALPM_ICLK_BUS2) ? bus_div_ff :
                  (iclk == `ALPM_ICLK_ALT) ? alt_clk_tick : async_clk_tick;
    // ************************************************
    // start arbitration
    // ************************************************
    // software starts only count in run; trigger or continuous restart elsewhere
    // continuous mode stays parked after a stop3 abort so it cannot resume on its own
    assign start = converter_enable_ff && !busy && !stop2 &&
                   (sc2_ff[`ALPM_SC2_TRG] ? hw_trigger
                    : ((sw_start_ff && !in_low_power) ||
                       (sc1_ff[`ALPM_SC1_CONT] && !abort_stop3 && !lock_ff && !parked_ff)));
    alpm_conv_seq #(
        .CYC_W(8)
    ) u_seq (
        .core_clk(core_clk),
        .srst(srst),
        .tick(tick),
        .start(start),
        .abort(abort_stop3 || stop2),
        .cycles(`ALPM_CONV_CYC),
        .busy(busy),
        .done_ff(conv_done)
    );
    // ************************************************
    // compare and result transfer
    // ************************************************
    assign eff_result = mode_mask(cfg_ff[`ALPM_CFG_MODE_HI:`ALPM_CFG_MODE_LO], sar_result);
    assign diff = {1'b0, eff_result} - {1'b0, cmp_ff};
    assign cmp_ok = !sc2_ff[`ALPM_SC2_CFE] ||
                    (sc2_ff[`ALPM_SC2_CGT] ? !diff[10] : diff[10]);
    // ************************************************
    // bus decode
    // ************************************************
    // single-cycle slave: every access answered in the cycle it is seen
    assign avs_waitrequest = 1'b0;
    assign wr_hit = avs_write && be_ok(avs_byteenable);
    assign rd_hit = avs_read;
    // register file and converter state
    always @(posedge core_clk) begin
        if (srst || stop2) begin
            cfg_ff <= `ALPM_RST_CFG;
            sc2_ff <= `ALPM_RST_SC2;
            sc1_ff <= `ALPM_RST_SC1;
            conversion_complete_flag_ff <= 1'b0;
            result_ff <= 10'h000;
            cmp_ff <= 10'h000;
            lock_ff <= 1'b0;
            pin1_ff <= `ALPM_RST_BYTE;
            pin2_ff <= `ALPM_RST_BYTE;
            sw_start_ff <= 1'b0;
            converter_enable_ff <= 1'b0;
            parked_ff <= 1'b0;
        end else begin
            sw_start_ff <= 1'b0;
            converter_enable_ff <= 1'b1;
            // completion: flag set wins over a clearing access in the same cycle
            if (conv_done && cmp_ok && !lock_ff) begin
                conversion_complete_flag_ff <= 1'b1;
                result_ff <= sc2_ff[`ALPM_SC2_CFE] ? diff[9:0] : eff_result;
            end else if (wr_hit && avs_address == `ALPM_OFS_SC1) begin
                conversion_complete_flag_ff <= 1'b0;
            end else if (rd_hit && avs_address == `ALPM_OFS_RESL) begin
                conversion_complete_flag_ff <= 1'b0;
            end
            // high byte read freezes the result until the low byte is read
            if (rd_hit && avs_address == `ALPM_OFS_RESH) begin
                lock_ff <= 1'b1;
            end else if (rd_hit && avs_address == `ALPM_OFS_RESL) begin
                lock_ff <= 1'b0;
            end
            if (wr_hit) begin
                case (avs_address)
                    `ALPM_OFS_CFG: cfg_ff <= avs_writedata[7:0];
                    `ALPM_OFS_SC2: sc2_ff <= {1'b0, avs_writedata[6:4], 4'h0};
                    `ALPM_OFS_SC1: begin
                        sc1_ff <= {1'b0, avs_writedata[6:0]};
                        sw_start_ff <= 1'b1;
                        parked_ff <= 1'b0;
                        lock_ff <= 1'b0;
                    end
                    `ALPM_OFS_CMPH: cmp_ff[9:8] <= avs_writedata[1:0];
                    `ALPM_OFS_CMPL: cmp_ff[7:0] <= avs_writedata[7:0];
                    `ALPM_OFS_PIN1: pin1_ff <= avs_writedata[7:0];
                    `ALPM_OFS_PIN2: pin2_ff <= avs_writedata[7:0];
                    default: begin
                    end
                endcase
            end
            // a stop3 abort leaves result and flag alone and parks continuous mode
            if (abort_stop3) begin
                sw_start_ff <= 1'b0;
                parked_ff <= 1'b1;
            end
        end
    end
    // bus/2 divider, interrupt and pin outputs
    always @(posedge core_clk) begin
        if (srst || stop2) begin
            bus_div_ff <= 1'b0;
            complete_irq_ff <= 1'b0;
            pin_digital_disable_ff <= {N_PINS{1'b0}};
            channel_out_ff <= 5'h1F;
        end else begin
            bus_div_ff <= ~bus_div_ff;
            complete_irq_ff <= conversion_complete_flag_ff && sc1_ff[`ALPM_SC1_IEN];
            pin_digital_disable_ff <= {pin2_ff, pin1_ff};
            channel_out_ff <= sc1_ff[4:0];
        end
    end
    // read data and response, decoded combinationally for the zero-wait answer
    always @* begin
        avs_readdata = 32'h0000_0000;
        avs_response = 2'h0;
        case (avs_address)
            `ALPM_OFS_CFG: avs_readdata[7:0] = cfg_ff;
            `ALPM_OFS_SC2: avs_readdata[7:0] = {busy, sc2_ff[6:4], 4'h0};
            `ALPM_OFS_SC1: avs_readdata[7:0] = {conversion_complete_flag_ff, sc1_ff[6:0]};
            `ALPM_OFS_RESH: avs_readdata[7:0] = {6'h00, result_ff[9:8]};
            `ALPM_OFS_RESL: avs_readdata[7:0] = result_ff[7:0];
            `ALPM_OFS_CMPH: avs_readdata[7:0] = {6'h00, cmp_ff[9:8]};
            `ALPM_OFS_CMPL: avs_readdata[7:0] = cmp_ff[7:0];
            `ALPM_OFS_PIN1: avs_readdata[7:0] = pin1_ff;
            `ALPM_OFS_PIN2: avs_readdata[7:0] = pin2_ff;
            default: avs_response = 2'h2;
        endcase
    end
endmodule // alpm_ctrl
`default_nettype wire

/* File: dv/alpm_ctrl_props.sv */
// assertions on the ports of the low-power converter control
// assumes it is bound into alpm_ctrl; every signal is on core_clk
`default_nettype none
module alpm_ctrl_props #(
    parameter N_PINS = 16
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic [1:0] avs_response,
    input wire logic [1:0] power_mode,
    input wire logic complete_irq_ff,
    input wire logic converter_enable_ff,
    input wire logic [N_PINS-1:0] pin_digital_disable_ff,
    input wire logic [4:0] channel_out_ff
);
    // ****************
    // port relations
    // ****************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    // a write that lands; stop2 would wipe it at the same edge
    wire logic wr0 = avs_write && avs_byteenable[0] && power_mode != 2'h3;
    chk_stop2_off: assert property (power_mode == 2'h3 |=> !converter_enable_ff && channel_out_ff == 5'h1F)
        else $error("stop2 left the converter configured");
    chk_stop2_irq: assert property ((power_mode == 2'h3) [*2] |=> !complete_irq_ff)
        else $error("interrupt survives stop2");
    // the pin outputs follow the register one cycle later, so look two edges on
    chk_pin_write: assert property (wr0 && avs_address == 4'h7 ##1 power_mode != 2'h3
        |=> pin_digital_disable_ff[7:0] == $past(avs_writedata[7:0], 2))
        else $error("pin control write not applied");
    chk_chan_write: assert property (wr0 && avs_address == 4'h2 ##1 power_mode != 2'h3
        |=> channel_out_ff == $past(avs_writedata[4:0], 2))
        else $error("channel write not applied");
    chk_chan_read: assert property (avs_read && avs_address == 4'h2 && power_mode != 2'h3
        |=> channel_out_ff == $past(avs_readdata[4:0]))
        else $error("channel readback differs");
    chk_sc2_reserved: assert property (avs_read && avs_address == 4'h1 |-> avs_readdata[3:2] == 2'h0)
        else $error("reserved control bits read nonzero");
    chk_unmapped_resp: assert property (avs_read && avs_address > 4'h8 |-> avs_response == 2'h2)
        else $error("unmapped read not flagged");
    chk_upper_zero: assert property (avs_read |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read lanes nonzero");
    chk_irq_holds: assert property (complete_irq_ff && !avs_read && !avs_write && !$past(avs_read)
        && !$past(avs_write) && power_mode != 2'h3 |=> complete_irq_ff)
        else $error("interrupt dropped without software action");
    cov_irq: cover property ($rose(complete_irq_ff));
    cov_stop3: cover property (power_mode == 2'h2 ##1 complete_irq_ff);
    cov_lock: cover property (avs_read && avs_address == 4'h3);
endmodule // alpm_ctrl_props
bind alpm_ctrl alpm_ctrl_props #(.N_PINS(N_PINS)) u_props (.core_clk(core_clk), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_response(avs_response),
    .power_mode(power_mode), .complete_irq_ff(complete_irq_ff), .converter_enable_ff(converter_enable_ff),
    .pin_digital_disable_ff(pin_digital_disable_ff), .channel_out_ff(channel_out_ff));
`default_nettype wire

/* File: dv/alpm_ctrl_bench.sv */
// self-checking bench for the low-power converter control
// assumes the core files and the checker are compiled before it
`default_nettype none
module alpm_ctrl_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 0, srst = 1, avs_read = 0, avs_write = 0, hw_trigger = 0, async_tick = 0, alt_tick = 0;
    logic avs_waitrequest, irq, en;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic [1:0] power_mode = 2'h0, avs_response, rsp;
    logic [1:0] ck [3] = '{2'h0, 2'h1, 2'h3};
    logic [9:0] sar = 10'h000;
    logic [15:0] pins;
    logic [4:0] chan;
    int mismatches = 0, checks_done = 0, res = 0, keep = 0;
    alpm_ctrl dut (.core_clk(core_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .power_mode(power_mode), .hw_trigger(hw_trigger), .async_clk_tick(async_tick), .alt_clk_tick(alt_tick),
        .sar_result(sar), .compare_hit_unused(1'b0), .complete_irq_ff(irq), .converter_enable_ff(en),
        .pin_digital_disable_ff(pins), .channel_out_ff(chan));
    initial forever #4 core_clk = ~core_clk;
    // random per-cycle ticks so the async and alternate clocks run irregularly against the bus
    always @(posedge core_clk) begin
        async_tick <= 1'($urandom);
        alt_tick <= 1'($urandom);
    end
    // ****************
    // helpers
    // ****************
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        int n = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) begin
            mismatches++;
            close_out();
        end
        q = avs_readdata;
        rsp = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
        bus(1'b0, a, 8'h00);
        chk(nm, q, {24'h0, e});
    endtask
    // bounded wait; a conversion is 23 ticks of a clock that may tick half the time
    task automatic wait_irq();
        int n = 0;
        while (irq !== 1'b1 && n < 400) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 400) begin
            mismatches++;
            close_out();
        end
    endtask
    // new analog value, then the control write that may start a conversion
    task automatic start(input logic [7:0] sc1);
        logic [9:0] v = 10'($urandom);
        sar <= v;
        res = v;
        bus(1'b1, 4'h2, sc1);
    endtask
    task automatic chk_res();
        rd(4'h3, 8'(res >> 8), "result high");
        rd(4'h4, 8'(res), "result low");
    endtask
    // ****************
    // tests
    // ****************
    initial begin
        void'($urandom(32'h4443));
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        rd(4'h2, 8'h1F, "first control reset");
        bus(1'b1, 4'h0, 8'h98);
        rd(4'h0, 8'h98, "config fields");
        bus(1'b1, 4'h1, 8'h7C);
        rd(4'h1, 8'h70, "second control fields");
        bus(1'b1, 4'h7, 8'h02);
        @(posedge core_clk);
        chk("pin disable", pins, 32'h0002);
        bus(1'b0, 4'h9, 8'h00);
        chk("unmapped response", rsp, 32'h2);
        bus(1'b1, 4'h1, 8'h00);
        $display("layout test done");
        foreach (ck[i]) begin
            bus(1'b1, 4'h0, 8'h08 | 8'(ck[i]));
            start(8'h41);
            power_mode <= 2'h1;
            wait_irq();
            rd(4'h2, 8'hC1, "flag in wait");
            chk_res();
            start(8'h41);
            rd(4'h1, 8'h00, "software start in wait");
            bus(1'b1, 4'h1, 8'h40);
            hw_trigger <= 1'b1;
            @(posedge core_clk);
            hw_trigger <= 1'b0;
            wait_irq();
            chk_res();
            bus(1'b1, 4'h1, 8'h00);
            power_mode <= 2'h0;
        end
        $display("wait test done");
        keep = res;
        bus(1'b1, 4'h0, 8'h08);
        start(8'h61);
        power_mode <= 2'h2;
        repeat (60) @(posedge core_clk);
        power_mode <= 2'h0;
        @(posedge core_clk);
        rd(4'h2, 8'h61, "no flag after abort");
        rd(4'h1, 8'h00, "idle after abort");
        res = keep;
        chk_res();
        repeat (60) @(posedge core_clk);
        rd(4'h1, 8'h00, "no restart after stop3");
        chk("no interrupt after abort", irq, 32'h0);
        $display("stop3 abort test done");
        bus(1'b1, 4'h0, 8'h0B);
        start(8'h41);
        power_mode <= 2'h2;
        wait_irq();
        chk_res();
        power_mode <= 2'h0;
        $display("stop3 async test done");
        start(8'h61);
        wait_irq();
        rd(4'h3, 8'(res >> 8), "locked high");
        sar <= ~sar;
        repeat (150) @(posedge core_clk);
        rd(4'h4, 8'(res), "locked low");
        $display("lock test done");
        power_mode <= 2'h3;
        repeat (2) @(posedge core_clk);
        chk("enable in stop2", en, 32'h0);
        power_mode <= 2'h0;
        @(posedge core_clk);
        for (int i = 0; i < 9; i++) rd(4'(i), i == 2 ? 8'h1F : 8'h00, "reset after stop2");
        chk("pins after stop2", pins, 32'h0);
        bus(1'b1, 4'h0, 8'h08);
        bus(1'b1, 4'h1, 8'h00);
        start(8'h41);
        wait_irq();
        chk_res();
        $display("stop2 test done");
        close_out();
    end
endmodule // alpm_ctrl_bench
`default_nettype wire
